// *** rtl/tops_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module tops_pin_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tops_sync_state_t;
   tops_sync_state_t s;
   tops_sync_state_t next_s;
   logic agree;

   // level accepted only once stages two and three agree
   always_comb begin
      next_s = s;
      next_s.s1 = pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      agree = (s.s2 == s.s3);
      if (agree) begin
         next_s.lvl = s.s2;
      end
      rise = agree && s.s2 && !s.lvl;
      fall = agree && !s.s2 && s.lvl;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// *** rtl/tops_pkg.sv ***
package tops_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL1 = 8'h00;
   localparam logic [7:0] ADDR_CTRL2 = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CNT = 8'h0C;
   localparam logic [7:0] ADDR_ALT_CNT = 8'h10;
   localparam logic [7:0] ADDR_CAP1 = 8'h14;
   localparam logic [7:0] ADDR_CAP2 = 8'h18;
   localparam logic [7:0] ADDR_CMP1 = 8'h1C;
   localparam logic [7:0] ADDR_CMP2 = 8'h20;
   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int C1_EDGE1 = 0;
   localparam int C1_EDGE2 = 1;
   localparam int C1_DURING = 2;
   localparam int C1_AFTER = 3;
   localparam int C1_CAP_IE = 4;
   localparam int C1_CMP_IE = 5;
   localparam int C2_FIRST_COMPARE_OUTPUT_ENABLE = 0;
   localparam int C2_OC2E = 1;
   localparam int C2_OPM = 2;
   localparam int C2_PWM = 3;
   localparam int C2_CLK_LO = 4;
   localparam int F_CAP1 = 4;
   localparam int F_CMP1 = 3;
   localparam int F_WRAP = 2;
   localparam int F_CAP2 = 1;
   localparam int F_CMP2 = 0;
   localparam int ST_FREEZE = 2;
   // ---------------------------------------------------------------
   // values and counts
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
   localparam logic [15:0] CNT_MAX = 16'hFFFF;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [1:0] CLK_DIV4 = 2'h0;
   localparam logic [1:0] CLK_DIV2 = 2'h1;
   localparam logic [1:0] CLK_DIV8 = 2'h2;
   localparam logic [1:0] CLK_EXT = 2'h3;
   localparam logic [2:0] DIV2_LAST = 3'h1;
   localparam logic [2:0] DIV4_LAST = 3'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** rtl/tops_prescale.sv ***
`timescale 1ns/100ps
`default_nettype none
module tops_prescale (
   input wire logic aclk,
   input wire logic aresetn,
   tops_tick_if.gen tk
);
   typedef struct packed {
      logic [2:0] div;
      logic tick;
   } tops_pre_state_t;
   tops_pre_state_t s;
   tops_pre_state_t next_s;
   logic [2:0] last;

   // divider stands still while frozen, so its phase is kept
   always_comb begin
      next_s = s;
      next_s.tick = 1'b0;
      case (tk.clock_select)
         tops_pkg::CLK_DIV2: last = tops_pkg::DIV2_LAST; // R10
         tops_pkg::CLK_DIV8: last = tops_pkg::DIV8_LAST; // R10
         default: last = tops_pkg::DIV4_LAST; // R10
      endcase
      if (!tk.freeze) begin // R19
         if (tk.clock_select == tops_pkg::CLK_EXT) begin
            next_s.tick = tk.ext_rise; // R10
         end else if (s.div >= last) begin
            next_s.div = 3'h0;
            next_s.tick = 1'b1;
         end else begin
            next_s.div = s.div + 3'h1;
         end
      end
   end

   assign tk.tick = s.tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule
`default_nettype wire

// *** rtl/tops_tick_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface tops_tick_if;
   logic [1:0] clock_select;
   logic freeze;
   logic ext_rise;
   logic tick;
   modport gen (input clock_select, input freeze, input ext_rise, output tick);
   modport user (output clock_select, output freeze, output ext_rise, input tick);
endinterface
`default_nettype wire

// *** rtl/tops_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// (R01) single-pulse mode uses capture one, compare one
// (R02) pulse start: capture, reload FFFC, drive level
// (R03) compare one match ends pulse
// (R04) capture flag with enable raises interrupt
// (R05) flags clear: status read then low access
// (R06) no compare-one flag in single-pulse mode
// (R07) pwm select overrides single-pulse select
// (R08) capture two still works, one resets counter
// (R09) compare two flags only, no waveform
// (R10) prescale 2, 4, 8 or external clock
// (R11) software configures everything before enabling
// (R12) capture one edge chosen by control bit
// (R13) output enable dedicates compare pin
// (R14) status resets zero; pwm sets bit seven
// (R15) bit six: compare one match flag
// (R16) bit five: wrap flag, counter access clears
// (R17) bit four: capture two flag
// (R18) bit three: compare two match flag
// (R19) freeze stops counter and compare pins
// (R20) reserved status bits kept zero
// (R21) counter increments per tick and wraps
module tops_timer (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic first_capture_pin,
   input wire logic second_capture_pin,
   input wire logic ext_timer_clock,
   output logic first_compare_pin,
   output logic first_compare_pin_oe_n,
   output logic second_compare_pin,
   output logic second_compare_pin_oe_n,
   output logic capture_irq,
   output logic compare_irq
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [7:0] timer_control_one;
      logic [7:0] timer_control_two;
      logic timer_freeze;
      logic [4:0] flags;
      logic [4:0] armed;
      logic [15:0] cnt;
      logic [15:0] first_capture_value;
      logic [15:0] second_capture_value;
      logic [15:0] first_compare_value;
      logic [15:0] second_compare_value;
      logic pin1;
      logic pin2;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } tops_state_t;
   tops_state_t s;
   tops_state_t next_s;

   logic rise1;
   logic fall1;
   logic rise2;
   logic fall2;
   logic ext_rise;
   logic wr_take;
   logic rd_take;
   logic pwm_on;
   logic opm_on;
   logic edge1;
   logic edge2;
   logic tick;
   logic match1;
   logic match2;
   logic [4:0] set_f;
   logic [4:0] clr_f;
   logic [7:0] acc_addr;
   logic acc;
   logic status_rd;
   logic wr_ok;
   logic rd_ok;
   logic [31:0] rd_val;

   tops_tick_if tk ();

   // ---------------------------------------------------------------
   // pins and prescaler
   // ---------------------------------------------------------------
   tops_pin_sync u_cap1 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(first_capture_pin),
      .rise(rise1),
      .fall(fall1)
   );
   tops_pin_sync u_cap2 (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(second_capture_pin),
      .rise(rise2),
      .fall(fall2)
   );
   tops_pin_sync u_ext (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin(ext_timer_clock),
      .rise(ext_rise),
      .fall()
   );
   tops_prescale u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .tk(tk.gen)
   );

   assign tk.clock_select = s.timer_control_two[tops_pkg::C2_CLK_LO +: 2]; // R10
   assign tk.freeze = s.timer_freeze; // R19
   assign tk.ext_rise = ext_rise;
   // a tick already in flight when freeze lands is dropped here
   assign tick = tk.tick && !s.timer_freeze; // R19

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_s = s;
      wr_take = s_axi_awvalid && s_axi_wvalid && !s.bvalid;
      rd_take = s_axi_arvalid && !s.rvalid;
      pwm_on = s.timer_control_two[tops_pkg::C2_PWM];
      opm_on = s.timer_control_two[tops_pkg::C2_OPM] && !pwm_on; // R07
      edge1 = s.timer_control_one[tops_pkg::C1_EDGE1] ? rise1 : fall1; // R12
      edge2 = s.timer_control_one[tops_pkg::C1_EDGE2] ? rise2 : fall2;
      match1 = tick && (s.cnt == s.first_compare_value);
      match2 = tick && (s.cnt == s.second_compare_value);
      set_f = 5'h00;
      clr_f = 5'h00;
      status_rd = rd_take && (s_axi_araddr == tops_pkg::ADDR_STATUS);
      // a write and a read in one cycle: only the read's word clears a flag
      acc_addr = rd_take ? s_axi_araddr : s_axi_awaddr;
      acc = rd_take || wr_take;

      // counter
      if (tick) begin
         next_s.cnt = s.cnt + 16'h0001; // R21
         if (s.cnt == tops_pkg::CNT_MAX) begin
            set_f[tops_pkg::F_WRAP] = 1'b1; // R16
         end
      end
      if (pwm_on) begin
         if (match1) begin
            next_s.pin1 = s.timer_control_one[tops_pkg::C1_AFTER];
         end
         if (match2) begin
            next_s.cnt = tops_pkg::CNT_RELOAD;
            next_s.pin1 = s.timer_control_one[tops_pkg::C1_DURING];
            set_f[tops_pkg::F_CAP1] = 1'b1; // R14
         end
      end else if (opm_on) begin // R01
         if (match1) begin
            next_s.pin1 = s.timer_control_one[tops_pkg::C1_AFTER]; // R03 R06
         end
         if (match2) begin
            set_f[tops_pkg::F_CMP2] = 1'b1; // R09
         end
         if (edge1 && !s.timer_freeze) begin
            next_s.first_capture_value = s.cnt; // R02
            next_s.cnt = tops_pkg::CNT_RELOAD; // R02 R08
            next_s.pin1 = s.timer_control_one[tops_pkg::C1_DURING]; // R02
            set_f[tops_pkg::F_CAP1] = 1'b1; // R02
         end
      end else begin
         if (match1) begin
            next_s.pin1 = s.timer_control_one[tops_pkg::C1_AFTER];
            set_f[tops_pkg::F_CMP1] = 1'b1; // R15
         end
         if (match2) begin
            next_s.pin2 = s.timer_control_one[tops_pkg::C1_DURING];
            set_f[tops_pkg::F_CMP2] = 1'b1; // R18
         end
         if (edge1) begin
            next_s.first_capture_value = s.cnt;
            set_f[tops_pkg::F_CAP1] = 1'b1;
         end
      end
      if (!pwm_on && edge2) begin
         next_s.second_capture_value = s.cnt; // R08
         set_f[tops_pkg::F_CAP2] = 1'b1; // R17
      end

      // two-step clear; the alternate counter word never clears
      if (acc) begin
         case (acc_addr)
            tops_pkg::ADDR_CAP1: clr_f[tops_pkg::F_CAP1] = s.armed[tops_pkg::F_CAP1]; // R05
            tops_pkg::ADDR_CMP1: clr_f[tops_pkg::F_CMP1] = s.armed[tops_pkg::F_CMP1]; // R15
            tops_pkg::ADDR_CNT: clr_f[tops_pkg::F_WRAP] = s.armed[tops_pkg::F_WRAP]; // R16
            tops_pkg::ADDR_CAP2: clr_f[tops_pkg::F_CAP2] = s.armed[tops_pkg::F_CAP2]; // R05
            tops_pkg::ADDR_CMP2: clr_f[tops_pkg::F_CMP2] = s.armed[tops_pkg::F_CMP2]; // R18
            default: clr_f = 5'h00;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_s.flags = (s.flags & ~clr_f) | set_f; // R05
      next_s.armed = (s.armed | (status_rd ? s.flags : 5'h00)) & ~clr_f; // R05

      // register writes
      wr_ok = 1'b1;
      if (wr_take) begin
         case (s_axi_awaddr)
            tops_pkg::ADDR_CTRL1: begin
               if (s_axi_wstrb[0]) begin
                  next_s.timer_control_one = s_axi_wdata[7:0];
               end
            end
            tops_pkg::ADDR_CTRL2: begin
               if (s_axi_wstrb[0]) begin
                  next_s.timer_control_two = s_axi_wdata[7:0];
               end
            end
            tops_pkg::ADDR_STATUS: begin
               if (s_axi_wstrb[0]) begin
                  next_s.timer_freeze = s_axi_wdata[tops_pkg::ST_FREEZE]; // R19
               end
            end
            tops_pkg::ADDR_CMP1: begin
               if (s_axi_wstrb[0]) begin
                  next_s.first_compare_value[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  next_s.first_compare_value[15:8] = s_axi_wdata[15:8];
               end
            end
            tops_pkg::ADDR_CMP2: begin
               if (s_axi_wstrb[0]) begin
                  next_s.second_compare_value[7:0] = s_axi_wdata[7:0];
               end
               if (s_axi_wstrb[1]) begin
                  next_s.second_compare_value[15:8] = s_axi_wdata[15:8];
               end
            end
            tops_pkg::ADDR_CNT, tops_pkg::ADDR_ALT_CNT, tops_pkg::ADDR_CAP1, tops_pkg::ADDR_CAP2: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
         endcase
         next_s.bvalid = 1'b1;
         next_s.bresp = wr_ok ? tops_pkg::RESP_OKAY : tops_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         next_s.bvalid = 1'b0;
      end

      // register reads
      rd_ok = 1'b1;
      case (s_axi_araddr)
         tops_pkg::ADDR_CTRL1: rd_val = {24'h000000, s.timer_control_one};
         tops_pkg::ADDR_CTRL2: rd_val = {24'h000000, s.timer_control_two};
         tops_pkg::ADDR_STATUS: rd_val = {24'h000000, s.flags, s.timer_freeze, 2'h0}; // R14 R20
         tops_pkg::ADDR_CNT, tops_pkg::ADDR_ALT_CNT: rd_val = {16'h0000, s.cnt};
         tops_pkg::ADDR_CAP1: rd_val = {16'h0000, s.first_capture_value};
         tops_pkg::ADDR_CAP2: rd_val = {16'h0000, s.second_capture_value};
         tops_pkg::ADDR_CMP1: rd_val = {16'h0000, s.first_compare_value};
         tops_pkg::ADDR_CMP2: rd_val = {16'h0000, s.second_compare_value};
         default: begin
            rd_val = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
      if (rd_take) begin
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_val;
         next_s.rresp = rd_ok ? tops_pkg::RESP_OKAY : tops_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         next_s.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign s_axi_awready = wr_take;
   assign s_axi_wready = wr_take;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_bresp = s.bresp;
   assign s_axi_arready = rd_take;
   assign s_axi_rvalid = s.rvalid;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   // pin two is held low in single-pulse mode, but still drives when its enable is set and not frozen
   assign first_compare_pin = s.pin1;
   assign second_compare_pin = s.pin2 && !opm_on; // R09
   assign first_compare_pin_oe_n = !(s.timer_control_two[tops_pkg::C2_FIRST_COMPARE_OUTPUT_ENABLE] && !s.timer_freeze); // R13 R19
   assign second_compare_pin_oe_n = !(s.timer_control_two[tops_pkg::C2_OC2E] && !s.timer_freeze); // R19
   assign capture_irq = s.flags[tops_pkg::F_CAP1] && s.timer_control_one[tops_pkg::C1_CAP_IE]; // R04
   assign compare_irq = (s.flags[tops_pkg::F_CMP1] || s.flags[tops_pkg::F_CMP2])
                        && s.timer_control_one[tops_pkg::C1_CMP_IE]; // R06

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence pulse_start;
      opm_on && edge1 && !s.timer_freeze;
   endsequence
   sequence wrap_armed_access;
      s.armed[tops_pkg::F_WRAP] && acc && acc_addr == tops_pkg::ADDR_CNT && !set_f[tops_pkg::F_WRAP];
   endsequence

   a_pulse_reload: assert property (pulse_start |=> s.cnt == tops_pkg::CNT_RELOAD && s.flags[tops_pkg::F_CAP1]) // R02
      else $error("pulse start did not reload and flag");
   a_pulse_level: assert property (pulse_start |=> // R02
      first_compare_pin == $past(s.timer_control_one[tops_pkg::C1_DURING]))
      else $error("pulse level wrong at start");
   a_pulse_end: assert property (opm_on && match1 && !edge1 |=> // R03
      first_compare_pin == $past(s.timer_control_one[tops_pkg::C1_AFTER]))
      else $error("pulse did not end on compare match");
   a_no_cmp1_flag: assert property (opm_on && !s.flags[tops_pkg::F_CMP1] |=> !s.flags[tops_pkg::F_CMP1]) // R06
      else $error("compare one flag set in single pulse mode");
   a_pwm_wins: assert property (pwm_on && edge1 |=> $stable(s.first_capture_value)) // R07
      else $error("capture one acted in pwm mode");
   a_cap_irq: assert property ($rose(s.flags[tops_pkg::F_CAP1]) && // R04
      s.timer_control_one[tops_pkg::C1_CAP_IE] |-> capture_irq)
      else $error("capture interrupt missing");
   a_wrap_clear: assert property (wrap_armed_access |=> !s.flags[tops_pkg::F_WRAP]) // R16
      else $error("wrap flag not cleared by counter access");
   a_wrap_set: assert property (tick && s.cnt == tops_pkg::CNT_MAX && !pwm_on && !(opm_on && edge1) // R16 R21
      |=> s.flags[tops_pkg::F_WRAP] && s.cnt == tops_pkg::CNT_RESET)
      else $error("wrap not flagged");
   a_freeze_hold: assert property (s.timer_freeze |=> $stable(s.cnt)) // R19
      else $error("counter moved while frozen");
   a_freeze_pins: assert property (s.timer_freeze |-> first_compare_pin_oe_n && second_compare_pin_oe_n) // R19
      else $error("compare pin driven while frozen");
   a_cap2_load: assert property (!pwm_on && edge2 |=> // R08 R17
      s.flags[tops_pkg::F_CAP2] && s.second_capture_value == $past(s.cnt))
      else $error("capture two not taken");
endmodule
`default_nettype wire

// *** verif/tb_timer_one_pulse_and_status.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_timer_one_pulse_and_status;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, fire, load_level;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic cap1_pin, cap2_pin, ext_clk, cmp1_pin, cmp1_oe_n, cmp2_pin, cmp2_oe_n, capture_irq, compare_irq;
   logic [34:0] exp_r[$];
   logic [1:0] exp_b[$];
   logic [34:0] er;
   logic [15:0] n1, m2, held;
   int num_errors, n_tests, cycles, len;
   localparam int DIVS [4] = '{2, 4, 8, 6};
   localparam logic [1:0] SELS [4] = '{tops_pkg::CLK_DIV2, tops_pkg::CLK_DIV4, tops_pkg::CLK_DIV8, tops_pkg::CLK_EXT};
   localparam logic [1:0] OK = tops_pkg::RESP_OKAY;

   tops_timer uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .first_capture_pin(cap1_pin), .second_capture_pin(cap2_pin), .ext_timer_clock(ext_clk),
      .first_compare_pin(cmp1_pin), .first_compare_pin_oe_n(cmp1_oe_n), .second_compare_pin(cmp2_pin),
      .second_compare_pin_oe_n(cmp2_oe_n), .capture_irq(capture_irq), .compare_irq(compare_irq));

   tops_trigger_model partner (.aclk(aclk), .fire(fire), .first_compare_pin(cmp1_pin),
      .first_compare_pin_oe_n(cmp1_oe_n), .first_capture_pin(cap1_pin), .second_capture_pin(cap2_pin),
      .ext_timer_clock(ext_clk), .load_level(load_level));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task automatic summarize();
      if (num_errors == 0 && n_tests > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] resp);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {16'h0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      exp_b.push_back(resp);
      @(posedge aclk iff s_axi_awready === 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge aclk iff s_axi_bvalid === 1'b1);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic chk, input logic [1:0] resp, input logic [15:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      exp_r.push_back({chk, resp, 16'h0000, d});
      @(posedge aclk iff s_axi_arready === 1'b1);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk iff s_axi_rvalid === 1'b1);
      s_axi_rready <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // response watcher
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         er = exp_r.pop_front();
         held <= s_axi_rdata[15:0];
         if (er[34]) check({s_axi_rresp, s_axi_rdata}, er[33:0]);
      end
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) check(34'(s_axi_bresp), 34'(exp_b.pop_front()));
   end

   // a hang counts as a mismatch; normal run stays well under 1500 cycles
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, fire} = 7'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h00000000;
      s_axi_wstrb = 4'hF;
      num_errors = 0;
      n_tests = 0;
      cycles = 0;
      void'($urandom(32'hF346));
      n1 = 16'(20 + $urandom % 20);
      m2 = 16'(8 + $urandom % 8);
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0000);
      check(34'({cmp1_oe_n, cmp2_oe_n}), 34'h3);
      // both compare values are zero: the first tick flags both, then freeze
      repeat (8) @(posedge aclk);
      wr(tops_pkg::ADDR_STATUS, 16'h0004, OK);
      rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h004C);
      rd(tops_pkg::ADDR_CAP1, 1'b0, OK, 16'h0000);
      rd(tops_pkg::ADDR_CAP2, 1'b0, OK, 16'h0000);
      rd(tops_pkg::ADDR_CNT, 1'b0, OK, 16'h0000);
      wr(tops_pkg::ADDR_CMP1, n1, OK);
      wr(tops_pkg::ADDR_CMP2, m2, OK);
      rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0004);
      rd(8'h40, 1'b1, tops_pkg::RESP_SLVERR, 16'h0000);
      wr(8'h40, 16'h00FF, tops_pkg::RESP_SLVERR);
      for (int i = 0; i < 4; i++) begin
         wr(tops_pkg::ADDR_CTRL1, (i % 2 == 0) ? 16'h0035 : 16'h0034, OK);
         wr(tops_pkg::ADDR_CTRL2, {10'h000, SELS[i], 4'h7}, OK);
         wr(tops_pkg::ADDR_STATUS, 16'h0000, OK);
         @(posedge aclk);
         fire <= 1'b1;
         @(posedge aclk);
         fire <= 1'b0;
         len = 0;
         while (load_level !== 1'b1 && len < 40) begin
            @(posedge aclk);
            len++;
         end
         check(34'(len < 12), 34'h1);
         len = 0;
         while (load_level === 1'b1 && len < 2000) begin
            @(posedge aclk);
            len++;
         end
         check(34'(len >= (3 + n1) * DIVS[i] && len <= (6 + n1) * DIVS[i]), 34'h1);
         check(34'({cmp2_pin, cmp2_oe_n, cmp1_oe_n, capture_irq, compare_irq}), 34'h03);
         rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h00B8);
         rd(tops_pkg::ADDR_CAP1, 1'b0, OK, 16'h0000);
         rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0038);
         rd(tops_pkg::ADDR_ALT_CNT, 1'b0, OK, 16'h0000);
         rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0038);
         rd(tops_pkg::ADDR_CNT, 1'b0, OK, 16'h0000);
         rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0018);
         wr(tops_pkg::ADDR_CMP2, m2, OK);
         rd(tops_pkg::ADDR_CAP2, 1'b0, OK, 16'h0000);
         rd(tops_pkg::ADDR_STATUS, 1'b1, OK, 16'h0000);
         check(34'({capture_irq, compare_irq}), 34'h0);
      end
      // pwm with single-pulse set: a matching edge must capture nothing
      wr(tops_pkg::ADDR_CTRL1, 16'h0035, OK);
      wr(tops_pkg::ADDR_CTRL2, {10'h000, tops_pkg::CLK_DIV2, 4'hF}, OK);
      rd(tops_pkg::ADDR_CAP1, 1'b0, OK, 16'h0000);
      for (int k = 0; k < 2; k++) begin
         if (k == 1) begin
            // frozen single-pulse: no capture, no reload, both pins release
            wr(tops_pkg::ADDR_CTRL1, 16'h0034, OK);
            wr(tops_pkg::ADDR_CTRL2, {10'h000, tops_pkg::CLK_DIV2, 4'h7}, OK);
            wr(tops_pkg::ADDR_STATUS, 16'h0004, OK);
         end
         @(posedge aclk);
         fire <= 1'b1;
         @(posedge aclk);
         fire <= 1'b0;
         repeat (20) @(posedge aclk);
         rd(tops_pkg::ADDR_CAP1, 1'b1, OK, held);
      end
      check(34'({load_level, cmp1_pin, cmp1_oe_n, cmp2_oe_n}), 34'h3);
      summarize();
   end
endmodule
`default_nettype wire

// *** verif/tops_trigger_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// trigger source and pulse load
// ---------------------------------------------------------------
module tops_trigger_model (
   input wire logic aclk,
   input wire logic fire,
   input wire logic first_compare_pin,
   input wire logic first_compare_pin_oe_n,
   output logic first_capture_pin,
   output logic second_capture_pin,
   output logic ext_timer_clock,
   output logic load_level
);
   logic [4:0] gap;
   // load has a pull-down: a released pin reads low, never the last level
   assign load_level = first_compare_pin_oe_n ? 1'b0 : first_compare_pin;
   initial begin
      first_capture_pin = 1'b0;
      second_capture_pin = 1'b0;
      gap = 5'h00;
   end
   // free-running, unrelated to aclk, six cycles a period
   initial begin
      ext_timer_clock = 1'b0;
      forever #15 ext_timer_clock = ~ext_timer_clock;
   end
   // each request flips the trigger, then one low-high-low on capture two
   always @(posedge aclk) begin
      if (fire) begin
         first_capture_pin <= ~first_capture_pin;
         gap <= 5'h14;
      end else if (gap != 5'h00) begin
         gap <= gap - 5'h01;
         if (gap == 5'h0A) second_capture_pin <= 1'b1;
         if (gap == 5'h02) second_capture_pin <= 1'b0;
      end
   end
endmodule
`default_nettype wire
